//--- hsf_pkg.sv
// Constants, types and register map of the hot-swap fault sequencer
package hsf_pkg;

    // Timebase
    localparam int CLK_PERIOD_NS = 25;
    localparam int SHORT_TICK_NS = 32000;
    localparam int LONG_TICK_NS = 128000;
    localparam int SHORT_TICK_CYC = SHORT_TICK_NS / CLK_PERIOD_NS;
    localparam int LONG_TICK_CYC = LONG_TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 13;

    // Current-limit duration, rounded up to whole ticks
    localparam int SHORT_LIMIT_NS = 500000;
    localparam int LONG_LIMIT_NS = 2000000;
    localparam int SHORT_LIMIT_TICKS = (SHORT_LIMIT_NS + SHORT_TICK_NS - 1) / SHORT_TICK_NS;
    localparam int LONG_LIMIT_TICKS = (LONG_LIMIT_NS + LONG_TICK_NS - 1) / LONG_TICK_NS;
    localparam int INTEG_W = 6;

    // Decay is this many times slower than the rise
    localparam int DECAY_RATIO = 128;
    localparam int DECAY_W = 7;

    // Restart holdoff in ticks
    localparam int HOLDOFF_TICKS_DEF = 16;
    localparam int HOLD_W = 8;

    // Register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'hC;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h1;

    // Event bits, shared by status and mask
    localparam int EV_W = 4;
    localparam int EV_OC = 0;
    localparam int EV_OT = 1;
    localparam int EV_PG = 2;
    localparam int EV_UV = 3;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    // State register layout
    localparam int ST_DRIVE_BIT = 0;
    localparam int ST_PG_BIT = 1;
    localparam int ST_FSM_LSB = 4;
    localparam int ST_INTEG_LSB = 8;

    localparam int NUM_FLAGS = 8;

    // Comparator flags, all from the analog front end
    typedef struct packed {
        logic supply_low_sense;
        logic supply_high_sense;
        logic lockout_clear;
        logic sense_below_trip;
        logic limit_trip;
        logic overtemp;
        logic drain_low;
        logic gate_full;
    } hsf_flags_t;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_ON = 3'h1,
        ST_HOLD = 3'h2,
        ST_LATCH = 3'h3
    } hsf_state_t;

endpackage

//--- hsf_sequencer.sv
// Fault sequencer: start-up gating, overcurrent integrator, thermal and restart handling
// Functional notes
// (RQ1) Drive on only when all start conditions hold
// (RQ2) Any fault forces drive off at once
// (RQ3) Integrator counts up per overcurrent tick
// (RQ4) Overcurrent shorter than tick counts one tick
// (RQ5) Integrator at duration limit raises overcurrent fault
// (RQ6) Integrator decays 128 times slower than rise
// (RQ7) Duty above 1/128 eventually faults
// (RQ8) Overtemperature forces drive off, thermal fault
// (RQ9) Autoretry holds off after thermal fault
// (RQ10) Autoretry restarts only after overtemperature clears
// (RQ11) Latched thermal fault cleared by sense toggle
// (RQ12) Latched restart still waits the holdoff
// (RQ13) Autoretry restarts after overcurrent holdoff
// (RQ14) Latched overcurrent cleared by sense toggle only
// (RQ15) Power good on drain low, off only undervoltage; code also needs gate_full and drops it on lockout, hold or latch
// (RQ16) Lockout keeps drive off regardless of sense
// (RQ17) Variants and holdoff are build parameters
// (RQ18) Flags synchronised, all state cleared on reset; code resets ctrl enable to 1 and power good output to its inactive level
`timescale 1ns/1ps
module hsf_sequencer
    import hsf_pkg::*;
#(
    parameter bit LONG_DURATION = 1'b0,
    parameter bit LATCHED = 1'b0,
    parameter bit PG_ACTIVE_HIGH = 1'b0,
    parameter int LONG_TICK_CYCLES = LONG_TICK_CYC,
    parameter int HOLDOFF_TICKS = HOLDOFF_TICKS_DEF
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Comparator flags
    input wire hsf_flags_t flags_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    // Outputs
    output logic drive_en_o,
    output logic power_good_out_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int TICK_CYC = LONG_DURATION ? LONG_TICK_CYCLES : SHORT_TICK_CYC; // [RQ17]
    localparam int LIMIT_TICKS = LONG_DURATION ? LONG_LIMIT_TICKS : SHORT_LIMIT_TICKS;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam logic [INTEG_W-1:0] INTEG_LIMIT = INTEG_W'(LIMIT_TICKS);
    localparam logic [DECAY_W-1:0] DECAY_LAST = DECAY_W'(DECAY_RATIO - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLDOFF_TICKS);

    logic [NUM_FLAGS-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
    logic [NUM_FLAGS-1:0] s1_next, s2_next, s3_next, flt_next;
    hsf_flags_t flt;

    always_comb begin
        s1_next = flags_i;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_filt
            assign flt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : flt_reg[gi]; // [RQ18]
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            flt_reg <= '0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            flt_reg <= flt_next;
        end
    end

    assign flt = hsf_flags_t'(flt_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Timebase and overcurrent integrator
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [INTEG_W-1:0] integ_reg, integ_next;
    logic [DECAY_W-1:0] decay_reg, decay_next;
    logic oc_seen_reg, oc_seen_next;
    logic tick;
    logic oc_fault;
    hsf_state_t state_reg, state_next;

    always_comb begin
        tick = (tick_cnt_reg == TICK_LAST);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
        integ_next = integ_reg;
        decay_next = decay_reg;
        oc_fault = 1'b0;
        // Any trip inside a tick window is held to the tick edge
        oc_seen_next = oc_seen_reg | flt.limit_trip; // [RQ4]
        if (tick) begin
            oc_seen_next = flt.limit_trip;
        end
        if (state_reg != ST_ON) begin
            integ_next = '0;
            decay_next = '0;
        end else if (tick) begin
            if (oc_seen_reg) begin
                integ_next = integ_reg + 1'b1; // [RQ3]
                decay_next = '0;
                if (integ_next >= INTEG_LIMIT) begin
                    oc_fault = 1'b1; // [RQ5] [RQ7]
                end
            end else if (integ_reg != '0) begin
                decay_next = decay_reg + 1'b1;
                if (decay_reg == DECAY_LAST) begin
                    integ_next = integ_reg - 1'b1; // [RQ6]
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= '0;
            integ_reg <= '0;
            decay_reg <= '0;
            oc_seen_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            integ_reg <= integ_next;
            decay_reg <= decay_next;
            oc_seen_reg <= oc_seen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch sequencing
    logic [HOLD_W-1:0] hold_reg, hold_next;
    logic uv_low_seen_reg, uv_low_seen_next;
    logic drive_reg, drive_next;
    logic pg_reg, pg_next;
    logic pg_out_reg, pg_out_next;
    logic sw_enable;
    logic run_ok;
    logic start_ok;
    logic ot_event, uv_event;

    always_comb begin
        run_ok = flt.supply_low_sense && !flt.supply_high_sense
                 && flt.lockout_clear && sw_enable; // [RQ16]
        start_ok = run_ok && flt.sense_below_trip; // [RQ1]
        state_next = state_reg;
        hold_next = hold_reg;
        uv_low_seen_next = uv_low_seen_reg;
        ot_event = 1'b0;
        uv_event = 1'b0;
        case (state_reg)
            ST_OFF: begin
                if (start_ok && !flt.overtemp) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (flt.overtemp) begin
                    ot_event = 1'b1; // [RQ8]
                    state_next = LATCHED ? ST_LATCH : ST_HOLD;
                end else if (oc_fault) begin
                    state_next = LATCHED ? ST_LATCH : ST_HOLD; // [RQ2]
                end else if (!run_ok) begin
                    uv_event = !flt.supply_low_sense;
                    state_next = ST_OFF;
                end
                hold_next = '0;
                uv_low_seen_next = 1'b0;
            end
            ST_HOLD: begin
                if (tick && hold_reg != HOLD_LAST) begin
                    hold_next = hold_reg + 1'b1; // [RQ9] [RQ12]
                end
                if (hold_reg == HOLD_LAST && !flt.overtemp) begin
                    state_next = ST_OFF; // [RQ10] [RQ13]
                end
            end
            ST_LATCH: begin
                if (!flt.supply_low_sense) begin
                    uv_low_seen_next = 1'b1;
                end else if (uv_low_seen_reg) begin
                    state_next = ST_HOLD; // [RQ11] [RQ14]
                    hold_next = '0;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        // Drive only while staying on, so faults drop it the next edge
        drive_next = (state_next == ST_ON); // [RQ2]
        pg_next = pg_reg;
        if (!flt.supply_low_sense || !flt.lockout_clear
            || state_reg == ST_HOLD || state_reg == ST_LATCH) begin
            pg_next = 1'b0; // [RQ15]
        end else if (state_reg == ST_ON && flt.drain_low && flt.gate_full) begin
            pg_next = 1'b1; // [RQ15]
        end
        pg_out_next = PG_ACTIVE_HIGH ? pg_next : !pg_next; // [RQ17]
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_OFF;
            hold_reg <= '0;
            uv_low_seen_reg <= 1'b0;
            drive_reg <= 1'b0;
            pg_reg <= 1'b0;
            pg_out_reg <= !PG_ACTIVE_HIGH;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            uv_low_seen_reg <= uv_low_seen_next;
            drive_reg <= drive_next;
            pg_reg <= pg_next;
            pg_out_reg <= pg_out_next;
        end
    end

    assign drive_en_o = drive_reg;
    assign power_good_out_o = pg_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port and interrupt
    logic ctrl_en_reg, ctrl_en_next;
    logic [EV_W-1:0] status_reg, status_next;
    logic [EV_W-1:0] mask_reg, mask_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [EV_W-1:0] events;

    always_comb begin
        events = '0;
        events[EV_OC] = oc_fault && state_reg == ST_ON && !flt.overtemp;
        events[EV_OT] = ot_event;
        events[EV_PG] = pg_next && !pg_reg;
        events[EV_UV] = uv_event;
        ctrl_en_next = ctrl_en_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL: ctrl_en_next = reg_wdata_i[CTRL_EN_BIT];
                REG_STATUS: status_next = status_reg & ~reg_wdata_i[EV_W-1:0];
                REG_MASK: mask_next = reg_wdata_i[EV_W-1:0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        status_next = status_next | events;
        rdata_next = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: rdata_next[CTRL_EN_BIT] = ctrl_en_reg;
                REG_STATUS: rdata_next[EV_W-1:0] = status_reg;
                REG_MASK: rdata_next[EV_W-1:0] = mask_reg;
                REG_STATE: begin
                    rdata_next[ST_DRIVE_BIT] = drive_reg;
                    rdata_next[ST_PG_BIT] = pg_reg;
                    rdata_next[ST_FSM_LSB +: 3] = state_reg;
                    rdata_next[ST_INTEG_LSB +: INTEG_W] = integ_reg;
                end
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_en_reg <= CTRL_EN_RST;
            status_reg <= '0;
            mask_reg <= MASK_RST;
            rdata_reg <= '0;
        end else begin
            ctrl_en_reg <= ctrl_en_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sw_enable = ctrl_en_reg;
    assign reg_rdata_o = rdata_reg;
    assign irq_o = |(status_reg & mask_reg);

endmodule // hsf_sequencer

//--- hsf_fet_model.sv
// Pass switch and load model: gate and drain follow the drive after a lag
`timescale 1ns/1ps
module hsf_fet_model (
    // Clock and drive
    input wire logic clock_i,
    input wire logic drive_i,
    input wire logic [7:0] lag_i,
    // Switch state
    output logic gate_full_o,
    output logic drain_low_o
);
    logic [7:0] ramp_reg;
    // Gate ramps while driven, collapses at once when released
    always_ff @(posedge clock_i) begin
        ramp_reg <= drive_i ? ramp_reg + {7'h0, ramp_reg != 8'hFF} : 8'h00;
    end
    assign gate_full_o = drive_i && (ramp_reg >= lag_i);
    assign drain_low_o = drive_i && (ramp_reg > lag_i);
endmodule // hsf_fet_model

//--- hsf_sequencer_asserts.sv
// Port assertions of the fault sequencer
`timescale 1ns/1ps
module hsf_sequencer_asserts
    import hsf_pkg::*;
#(
    parameter bit LONG_DURATION = 1'b0,
    parameter bit PG_ACTIVE_HIGH = 1'b0,
    parameter int LONG_TICK_CYCLES = LONG_TICK_CYC,
    parameter int HOLDOFF_TICKS = HOLDOFF_TICKS_DEF
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire hsf_flags_t flags_i,
    input wire logic drive_en_o,
    input wire logic power_good_out_o,
    input wire logic irq_o
);
    localparam int TICK = LONG_DURATION ? LONG_TICK_CYCLES : SHORT_TICK_CYC;
    localparam int OC_MAX = 17 * TICK + 8;
    localparam int HOLD_MIN = (HOLDOFF_TICKS - 1) * TICK;
    logic pg_act;
    logic start_ok;
    logic stay_ok;
    logic supply_ok;
    logic drive_d;
    logic fault_off;
    logic [15:0] oc_run;
    logic [15:0] off_run;
    logic [7:0] ok_run;
    assign pg_act = (power_good_out_o == PG_ACTIVE_HIGH);
    assign start_ok = flags_i.supply_low_sense && !flags_i.supply_high_sense
        && flags_i.lockout_clear && flags_i.sense_below_trip && !flags_i.overtemp;
    assign stay_ok = flags_i.supply_low_sense && flags_i.lockout_clear
        && !flags_i.overtemp && !flags_i.limit_trip;
    // Switch dropped with the supply in range: a fault, so a holdoff follows
    assign supply_ok = flags_i.supply_low_sense && !flags_i.supply_high_sense
        && flags_i.lockout_clear;
    ////////////////////////////////////////////////////////////////
    // Run lengths of overcurrent, off time and quiet supply
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            oc_run <= 16'h0;
            off_run <= 16'hFFFF;
            ok_run <= 8'h0;
            drive_d <= 1'b0;
            fault_off <= 1'b0;
        end else begin
            drive_d <= drive_en_o;
            if (drive_d && !drive_en_o) fault_off <= supply_ok;
            oc_run <= (drive_en_o && flags_i.limit_trip) ? oc_run + 16'h1 : 16'h0;
            off_run <= drive_en_o ? 16'h0 : off_run + {15'h0, off_run != 16'hFFFF};
            ok_run <= stay_ok ? ok_run + {7'h0, ok_run != 8'hFF} : 8'h0;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_rst; disable iff (1'b0) !rst_n_i |=> !drive_en_o && !irq_o && !pg_act; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_start; $rose(drive_en_o) |-> $past(start_ok, 3); endproperty
    a_start: assert property (p_start) else $error("drive without start");
    property p_ov; flags_i.supply_high_sense [*8] |-> !drive_en_o; endproperty
    a_ov: assert property (p_ov) else $error("drive in overvoltage");
    property p_ot; flags_i.overtemp [*8] |-> !drive_en_o; endproperty
    a_ot: assert property (p_ot) else $error("drive while hot");
    property p_uv; !flags_i.supply_low_sense [*8] |-> !drive_en_o && !pg_act; endproperty
    a_uv: assert property (p_uv) else $error("drive or pg in undervoltage");
    property p_oc; oc_run <= OC_MAX; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent not broken");
    property p_hold; $rose(drive_en_o) && fault_off |-> $past(off_run) >= HOLD_MIN; endproperty
    a_hold: assert property (p_hold) else $error("restart too early");
    property p_pg; pg_act && ok_run > 8'd100 |=> pg_act; endproperty
    a_pg: assert property (p_pg) else $error("pg dropped");
    c_on: cover property ($rose(drive_en_o));
    c_oc: cover property (oc_run == 16'd600);
    c_irq: cover property ($rose(irq_o));
endmodule // hsf_sequencer_asserts

//--- test_hsf_sequencer.sv
// Self-checking bench of the fault sequencer
`timescale 1ns/1ps
module test_hsf_sequencer;
    import hsf_pkg::*;
    localparam int T = 40;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    hsf_flags_t fl = 8'hB0;
    hsf_flags_t flags_i;
    logic [ADDR_W-1:0] reg_addr_i = 4'h0;
    logic [DATA_W-1:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic drive_en_o;
    logic power_good_out_o;
    logic irq_o;
    logic drain_low;
    logic gate_full;
    hsf_flags_t lat_flags;
    logic lat_drive;
    logic lat_pg;
    logic lat_drain;
    logic lat_gate;
    logic [7:0] lag = 8'h03;
    logic [64:0] note_q[$];
    logic [64:0] note;
    logic rd_d = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    int seed = 50201;
    assign flags_i = {fl[7:2], drain_low, gate_full};
    assign lat_flags = {fl[7:2], lat_drain, lat_gate};
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    hsf_sequencer #(.LONG_DURATION(1'b1), .LONG_TICK_CYCLES(T), .HOLDOFF_TICKS(2)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .flags_i(flags_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .drive_en_o(drive_en_o),
        .power_good_out_o(power_good_out_o), .irq_o(irq_o));
    hsf_fet_model u_fet (.clock_i(clock_i), .drive_i(drive_en_o), .lag_i(lag),
        .gate_full_o(gate_full), .drain_low_o(drain_low));
    // Latched variant with active-high power good on the same stimulus
    hsf_sequencer #(.LONG_DURATION(1'b1), .LATCHED(1'b1), .PG_ACTIVE_HIGH(1'b1),
        .LONG_TICK_CYCLES(T), .HOLDOFF_TICKS(2)) uut_lat (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .flags_i(lat_flags), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(), .drive_en_o(lat_drive), .power_good_out_o(lat_pg), .irq_o());
    hsf_fet_model u_fet_lat (.clock_i(clock_i), .drive_i(lat_drive), .lag_i(lag),
        .gate_full_o(lat_gate), .drain_low_o(lat_drain));
    ////////////////////////////////////////////////////////////////
    // Read results against the oldest note
    always @(posedge clock_i) begin
        if (rd_d) begin
            note = note_q.pop_front();
            n_compared++;
            if ({irq_o, reg_rdata_o & note[63:32]} !== {note[64], note[31:0]}) begin
                $display("[ERR] %0t read %h irq %b", $time, reg_rdata_o, irq_o);
                err_total++;
            end
        end
        rd_d <= reg_rd_i;
    end
    task automatic conclude();
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %0t pin %b expected %b", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, e, input logic i);
        @(posedge clock_i);
        note_q.push_back({i, m, e});
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    // Flag bits: 7 low sense, 6 high sense, 5 lockout, 4 below trip, 3 trip, 2 hot
    task automatic setf(input int b, input logic v);
        @(posedge clock_i);
        fl[b] <= v;
    endtask
    task automatic wait_drive(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && drive_en_o !== v; i++) @(posedge clock_i);
        if (drive_en_o !== v) begin
            $display("[ERR] %0t drive wait timed out", $time);
            err_total++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        wt(5);
        rst_n_i <= 1'b1;
        rd(REG_CTRL, 32'h1, 32'h1, 1'b0);
        rd(REG_MASK, 32'hF, 32'h0, 1'b0);
        rd(4'h2, 32'hFFFFFFFF, 32'h0, 1'b0);
        wait_drive(1'b1, 40);
        wt(50);
        rd(REG_STATE, 32'h3F73, 32'h13, 1'b0);
        wr(REG_MASK, 32'hF);
        rd(REG_STATUS, 32'hF, 32'h4, 1'b1);
        wr(REG_STATUS, 32'hF);
        setf(3, 1'b1);
        wt(14 * T);
        rd(REG_STATE, 32'h73, 32'h13, 1'b0);
        wait_drive(1'b0, 4 * T);
        rd(REG_STATUS, 32'hF, 32'h1, 1'b1);
        rd(REG_STATE, 32'h71, 32'h20, 1'b1);
        setf(3, 1'b0);
        wr(REG_STATUS, 32'h1);
        wait_drive(1'b1, 6 * T);
        chk(lat_drive, 1'b0);
        // Short pulse right after restart stays inside one tick
        setf(3, 1'b1);
        wt(2 + $unsigned($random(seed)) % 4);
        setf(3, 1'b0);
        wt(2 * T);
        rd(REG_STATE, 32'h3F71, 32'h111, 1'b1);
        wr(REG_STATUS, 32'hF);
        wt(130 * T);
        rd(REG_STATE, 32'h3F00, 32'h0, 1'b0);
        lag <= 8'd30;
        setf(2, 1'b1);
        wait_drive(1'b0, 12);
        wt(4 * T);
        rd(REG_STATE, 32'h71, 32'h20, 1'b1);
        rd(REG_STATUS, 32'hF, 32'h2, 1'b1);
        setf(2, 1'b0);
        wait_drive(1'b1, 4 * T);
        chk(lat_drive, 1'b0);
        wt(50);
        wr(REG_STATUS, 32'hF);
        setf(6, 1'b1);
        wt(100);
        rd(REG_STATE, 32'h3, 32'h2, 1'b0);
        setf(6, 1'b0);
        wait_drive(1'b1, 4 * T);
        setf(7, 1'b0);
        wt(20);
        rd(REG_STATUS, 32'hF, 32'h8, 1'b1);
        setf(7, 1'b1);
        wait_drive(1'b1, 40);
        wt(T - 8);
        chk(lat_drive, 1'b0);
        wt(2 * T);
        chk(lat_drive, 1'b1);
        setf(5, 1'b0);
        wt(100);
        rd(REG_STATE, 32'h1, 32'h0, 1'b1);
        setf(4, 1'b0);
        setf(5, 1'b1);
        wt(100);
        rd(REG_STATE, 32'h1, 32'h0, 1'b1);
        setf(4, 1'b1);
        wait_drive(1'b1, 4 * T);
        wt(50);
        chk(power_good_out_o, 1'b0);
        chk(lat_pg, 1'b1);
        wr(REG_MASK, 32'h0);
        rd(REG_STATUS, 32'hF, 32'hC, 1'b0);
        conclude();
    end
endmodule // test_hsf_sequencer
bind hsf_sequencer hsf_sequencer_asserts #(.LONG_DURATION(LONG_DURATION),
    .PG_ACTIVE_HIGH(PG_ACTIVE_HIGH), .LONG_TICK_CYCLES(LONG_TICK_CYCLES),
    .HOLDOFF_TICKS(HOLDOFF_TICKS)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .flags_i(flags_i), .drive_en_o(drive_en_o), .power_good_out_o(power_good_out_o),
    .irq_o(irq_o));
